/* tb/test_mult_tile.sv */
// self-checking bench of the multiplier tile
`timescale 1ns/1ps
`default_nettype none
`include "mult_tile_consts.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_mult_tile;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb;
    logic [17:0] op_a, op_b, ua, ub;
    logic sign_a, sign_b, usa, usb, result_signed;
    logic [35:0] result;
    int n_errors = 0;
    int check_count = 0;
    localparam logic [17:0] A_T = 18'h3ff85;
    localparam logic [17:0] B_T = 18'h20107;

    user_logic_model u_user (.pclk(pclk), .a_in(ua), .b_in(ub), .sa_in(usa), .sb_in(usb),
        .op_a(op_a), .op_b(op_b), .sign_a(sign_a), .sign_b(sign_b));
    mult_tile dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .op_a(op_a), .op_b(op_b), .sign_a(sign_a),
        .sign_b(sign_b), .result(result), .result_signed(result_signed));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [35:0] mul(input logic [17:0] a, input logic [17:0] b,
                                        input logic sa, input logic sb, input int n);
        logic [71:0] x, y, p;
        x = {54'h0, a};
        y = {54'h0, b};
        if (sa && a[n-1]) x = x - (72'h1 << n);
        if (sb && b[n-1]) y = y - (72'h1 << n);
        p = x * y;
        return p[35:0] & ((36'h1 << (2 * n)) - 36'h1);
    endfunction : mul

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic put(input logic [17:0] a, input logic [17:0] b, input logic sa,
                       input logic sb);
        @(posedge pclk);
        ua <= a;
        ub <= b;
        usa <= sa;
        usb <= sb;
    endtask : put

    task automatic edges(input int k);
        repeat (k) @(posedge pclk);
        @(negedge pclk);
    endtask : edges

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        apb(1'b0, `OFF_CFG, 32'h0);
        `CHK(rdat, 32'h0)
        apb(1'b0, `OFF_STATUS, 32'h0);
        `CHK(rdat, 32'h4)
        put(18'h3ffff, 18'h20001, 1'b1, 1'b1);
        edges(1);
        `CHK(result, 36'h3ffff * 36'h20001)
        `CHK(result_signed, 1'b0)
    endtask : t_reset

    task automatic t_signs();
        logic [35:0] lo, hi;
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, `OFF_CFG, 32'h600 | m);
            for (int i = 0; i < 4; i++) begin
                put(A_T, B_T, i[1], i[0]);
                edges(1);
                lo = mul({9'h0, A_T[8:0]}, {9'h0, B_T[8:0]}, i[1], i[0], 9);
                hi = mul({9'h0, A_T[17:9]}, {9'h0, B_T[17:9]}, i[1], i[0], 9);
                if (m == 0) begin
                    `CHK(result, mul(A_T, B_T, i[1], i[0], 18))
                end else begin
                    `CHK(result, {hi[17:0], lo[17:0]})
                end
                `CHK(result_signed, i[1] | i[0])
            end
        end
    endtask : t_signs

    task automatic t_inreg();
        apb(1'b1, `OFF_CFG, 32'h2);
        put(18'h00011, 18'h00003, 1'b0, 1'b0);
        edges(2);
        `CHK(result, 36'h33)
        put(18'h00005, 18'h00007, 1'b0, 1'b0);
        edges(1);
        `CHK(result, 36'h77)
        edges(1);
        `CHK(result, 36'h23)
        put(18'h00009, 18'h00002, 1'b0, 1'b0);
        ce <= 1'b0;
        edges(3);
        `CHK(result, 36'ha)
        @(posedge pclk);
        ce <= 1'b1;
        edges(1);
        `CHK(result, 36'h12)
    endtask : t_inreg

    task automatic t_pipe();
        logic [35:0] p0;
        p0 = mul(A_T, B_T, 1'b1, 1'b1, 18);
        apb(1'b1, `OFF_CFG, 32'h6ea);
        put(A_T, B_T, 1'b1, 1'b1);
        edges(4);
        apb(1'b0, `OFF_PROD_LO, 32'h0);
        `CHK(rdat, p0[31:0])
        put(18'h00003, 18'h00005, 1'b0, 1'b0);
        edges(2);
        `CHK(result, p0)
        `CHK(result_signed, 1'b1)
        edges(1);
        `CHK(result, 36'hf)
        `CHK(result_signed, 1'b0)
    endtask : t_pipe

    task automatic t_dual_out();
        apb(1'b1, `OFF_CFG, 32'h081);
        put({9'h2, 9'h3}, {9'h4, 9'h6}, 1'b0, 1'b0);
        edges(1);
        `CHK(result, {18'h8, 18'hf})
        edges(1);
        `CHK(result, {18'h8, 18'h12})
    endtask : t_dual_out

    task automatic t_bus();
        apb(1'b1, `OFF_STATUS, 32'hffffffff);
        `CHK(err, 1'b0)
        apb(1'b0, 12'h010, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rdat, 32'h0)
        apb(1'b0, `OFF_CFG, 32'h0);
        `CHK(rdat, 32'h081)
        // only the upper byte lane may change the control word
        @(posedge pclk);
        pstrb <= 4'h2;
        apb(1'b1, `OFF_CFG, 32'h0000_06ff);
        apb(1'b0, `OFF_CFG, 32'h0);
        `CHK(rdat, 32'h681)
        `CHK(err, 1'b0)
    endtask : t_bus

    task automatic close_out();
        if (n_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        ua = 18'h0;
        ub = 18'h0;
        usa = 1'b0;
        usb = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_signs();
        t_inreg();
        t_pipe();
        t_dual_out();
        t_bus();
        close_out();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (3000) @(posedge pclk);
        n_errors++;
        close_out();
    end
endmodule : test_mult_tile
`default_nettype wire

/* tb/user_logic_model.sv */
// user logic model that hands operands and sign controls to the tile
`timescale 1ns/1ps
`default_nettype none
module user_logic_model (
    // clock
    input wire logic pclk,
    // values wanted by the bench
    input wire logic [17:0] a_in,
    input wire logic [17:0] b_in,
    input wire logic sa_in,
    input wire logic sb_in,
    // operands to the tile
    output logic [17:0] op_a,
    output logic [17:0] op_b,
    output logic sign_a,
    output logic sign_b
);
    // registered like real fabric logic; a dual pair carries one sign bit per side
    always_ff @(posedge pclk) begin
        op_a <= a_in;
        op_b <= b_in;
        sign_a <= sa_in;
        sign_b <= sb_in;
    end
endmodule : user_logic_model
`default_nettype wire

/* verilog/mult_tile.sv */
// hard multiplier tile: 18x18 or dual 9x9 with optional registers and apb control
`timescale 1ns/1ps
`default_nettype none
`include "mult_tile_consts.svh"
module mult_tile
    import mult_tile_pkg::*;
(
    // clock, enable, clear
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // operands from user logic
    input wire logic [17:0] op_a,
    input wire logic [17:0] op_b,
    input wire logic sign_a,
    input wire logic sign_b,
    // product to user logic
    output logic [35:0] result,
    output logic result_signed
);
    tile_state_t st_reg;
    tile_state_t st_next;
    cfg_t cfg;
    logic dual;

    // ------------------------------------------------------------
    // staged operands and sign controls
    // ------------------------------------------------------------
    logic [8:0] a_lo_q;
    logic [8:0] a_hi_q;
    logic [8:0] b_lo_q;
    logic [8:0] b_hi_q;
    logic sa_q;
    logic sb_q;
    logic sa_in;
    logic sb_in;
    logic use_a_hi;
    logic use_b_hi;
    logic use_out_hi;

    assign cfg = st_reg.cfg;
    assign dual = (cfg.mode == MODE_DUAL);
    // in wide mode the upper section follows the lower section's choice
    assign use_a_hi = dual ? cfg.in_a_hi : cfg.in_a_lo;
    assign use_b_hi = dual ? cfg.in_b_hi : cfg.in_b_lo;
    assign use_out_hi = dual ? cfg.out_hi : cfg.out_lo;
    // a disabled sign control reads as unsigned
    assign sa_in = sign_a & cfg.sign_a_en;
    assign sb_in = sign_b & cfg.sign_b_en;

    pipe_stage #(.W(`SEC_W)) u_a_lo (
        .clk(pclk), .ce(ce), .aclr_n(presetn),
        .use_reg(cfg.in_a_lo), .d(op_a[8:0]), .q(a_lo_q)
    );
    pipe_stage #(.W(`SEC_W)) u_a_hi (
        .clk(pclk), .ce(ce), .aclr_n(presetn),
        .use_reg(use_a_hi), .d(op_a[17:9]), .q(a_hi_q)
    );
    pipe_stage #(.W(`SEC_W)) u_b_lo (
        .clk(pclk), .ce(ce), .aclr_n(presetn),
        .use_reg(cfg.in_b_lo), .d(op_b[8:0]), .q(b_lo_q)
    );
    pipe_stage #(.W(`SEC_W)) u_b_hi (
        .clk(pclk), .ce(ce), .aclr_n(presetn),
        .use_reg(use_b_hi), .d(op_b[17:9]), .q(b_hi_q)
    );
    pipe_stage #(.W(1)) u_sa (
        .clk(pclk), .ce(ce), .aclr_n(presetn),
        .use_reg(cfg.sign_a_reg), .d(sa_in), .q(sa_q)
    );
    pipe_stage #(.W(1)) u_sb (
        .clk(pclk), .ce(ce), .aclr_n(presetn),
        .use_reg(cfg.sign_b_reg), .d(sb_in), .q(sb_q)
    );

    // ------------------------------------------------------------
    // multiplier stage
    // ------------------------------------------------------------
    logic [35:0] p_wide;
    logic [17:0] p_lane0;
    logic [17:0] p_lane1;
    logic [35:0] prod;
    logic prod_signed;

    // operands of 10 to 18 bits sit sign extended in the wide multiplier
    signed_mult #(.W(`OP_W)) u_wide (
        .a({a_hi_q, a_lo_q}), .b({b_hi_q, b_lo_q}),
        .sa(sa_q), .sb(sb_q), .p(p_wide)
    );
    // both lanes see the same pair of sign controls
    signed_mult #(.W(`SEC_W)) u_lane0 (
        .a(a_lo_q), .b(b_lo_q), .sa(sa_q), .sb(sb_q), .p(p_lane0)
    );
    signed_mult #(.W(`SEC_W)) u_lane1 (
        .a(a_hi_q), .b(b_hi_q), .sa(sa_q), .sb(sb_q), .p(p_lane1)
    );

    assign prod = dual ? {p_lane1, p_lane0} : p_wide;
    assign prod_signed = sa_q | sb_q;

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    logic [17:0] out_lo_q;
    logic [18:0] out_hi_q;

    pipe_stage #(.W(`OP_W)) u_out_lo (
        .clk(pclk), .ce(ce), .aclr_n(presetn),
        .use_reg(cfg.out_lo), .d(prod[17:0]), .q(out_lo_q)
    );
    // the sign flag travels with the upper section
    pipe_stage #(.W(`OP_W + 1)) u_out_hi (
        .clk(pclk), .ce(ce), .aclr_n(presetn),
        .use_reg(use_out_hi), .d({prod_signed, prod[35:18]}), .q(out_hi_q)
    );

    assign result = {out_hi_q[17:0], out_lo_q};
    assign result_signed = out_hi_q[18];

    // ------------------------------------------------------------
    // apb register file
    // ------------------------------------------------------------
    logic hit;
    logic [31:0] rd_val;
    logic [`CFG_W-1:0] cfg_bits;
    logic [`CFG_W-1:0] cfg_wr;

    assign hit = (paddr == `OFF_CFG) || (paddr == `OFF_STATUS)
        || (paddr == `OFF_PROD_LO) || (paddr == `OFF_PROD_HI);
    assign cfg_bits = cfg;

    always_comb begin
        rd_val = 32'h0000_0000;
        case (paddr)
            `OFF_CFG: rd_val[`CFG_W-1:0] = cfg_bits;
            `OFF_STATUS: begin
                rd_val[`STAT_SIGNED_BIT] = result_signed;
                rd_val[`STAT_DUAL_BIT] = dual;
                rd_val[`STAT_CE_BIT] = ce;
            end
            `OFF_PROD_LO: rd_val = result[31:0];
            `OFF_PROD_HI: rd_val[`PROD_W-`PROD_HI_LSB-1:0] = result[35:`PROD_HI_LSB];
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // byte lanes: strobe 0 covers bits 7:0, strobe 1 bits 10:8
    always_comb begin
        cfg_wr = cfg_bits;
        if (pstrb[0]) begin
            cfg_wr[`CFG_LANE0_MSB:0] = pwdata[`CFG_LANE0_MSB:0];
        end
        if (pstrb[1]) begin
            cfg_wr[`CFG_LANE1_MSB:`CFG_LANE1_LSB] = pwdata[`CFG_LANE1_MSB:`CFG_LANE1_LSB];
        end
    end

    always_comb begin
        st_next = st_reg;
        if (ce) begin
            case (st_reg.phase)
                PH_IDLE: begin
                    // a setup cycle missed while ce was low is caught in the access phase
                    if (psel) begin
                        st_next.prdata = rd_val;
                        st_next.phase = PH_READY;
                    end
                end
                PH_READY: begin
                    if (psel && penable) begin
                        if (pwrite && paddr == `OFF_CFG) begin
                            st_next.cfg = cfg_t'(cfg_wr);
                        end
                        st_next.phase = PH_IDLE;
                    end else if (!psel) begin
                        st_next.phase = PH_IDLE;
                    end
                end
                default: st_next.phase = PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.cfg <= cfg_t'(`CFG_RESET);
            st_reg.prdata <= 32'h0000_0000;
            st_reg.phase <= PH_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pready = psel && penable && ce && (st_reg.phase == PH_READY);
    assign pslverr = pready && !hit;
    assign prdata = st_reg.prdata;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_sign_result: assert property (
        !cfg.out_lo && !dual |-> result_signed == (sa_q | sb_q))
        else $error("product sign flag wrong");
    a_unsigned_default: assert property (
        !cfg.sign_a_en && !cfg.sign_b_en && ce ##1 !cfg.sign_a_en && !cfg.sign_b_en
        |-> !sa_q && !sb_q) else $error("sign seen with sign controls unused");
    a_unsigned_full: assert property (
        !dual && !sa_q && !sb_q
        |-> p_wide == {18'h00000, a_hi_q, a_lo_q} * {18'h00000, b_hi_q, b_lo_q})
        else $error("unsigned wide product truncated");
    a_signed_full: assert property (
        !dual && sa_q && sb_q |-> $signed(p_wide)
        == $signed({{18{a_hi_q[8]}}, a_hi_q, a_lo_q})
        * $signed({{18{b_hi_q[8]}}, b_hi_q, b_lo_q}))
        else $error("signed wide product wrong");
    a_lane_split: assert property (
        dual |-> prod[17:0] == p_lane0 && prod[35:18] == p_lane1)
        else $error("dual lanes not placed in their sections");
    a_lane_indep: assert property (
        dual && !sa_q && !sb_q |-> p_lane1 == {9'h000, a_hi_q} * {9'h000, b_hi_q})
        else $error("upper lane depends on lower lane");
    a_out_latency: assert property (
        cfg.out_lo && !dual && ce ##1 cfg.out_lo && !dual |-> result == $past(prod))
        else $error("registered product not one cycle late");
    a_out_bypass: assert property (
        !cfg.out_lo && !dual |-> result == prod)
        else $error("bypassed output differs from product");
    a_sign_reg: assert property (
        cfg.sign_a_reg && ce ##1 cfg.sign_a_reg |-> sa_q == $past(sa_in))
        else $error("registered sign control not one cycle late");
    a_cfg_write: assert property (
        pready && pwrite && paddr == `OFF_CFG && pstrb[0]
        |=> cfg_bits[`CFG_LANE0_MSB:0] == $past(pwdata[`CFG_LANE0_MSB:0]))
        else $error("control write not taken");
    a_apb_wait: assert property (
        psel && !penable && ce && st_reg.phase == PH_IDLE ##1 penable && ce |-> pready)
        else $error("slave did not answer in the first access cycle");

    c_dual_signed: cover property (dual && sa_q && !sb_q && p_lane1 != 18'h00000);
    c_wide_mixed: cover property (!dual && !sa_q && sb_q && result_signed);
    c_cfg_write: cover property (pready && pwrite && paddr == `OFF_CFG);
    c_ce_hold: cover property (!ce [*3] ##1 ce);

endmodule : mult_tile
`default_nettype wire

/* verilog/mult_tile_consts.svh */
// constants of the hard multiplier tile: offsets, field positions, reset values
//
// Overview of operation
// - each operand section chooses input register or bypass on its own in dual mode; in wide mode the upper section follows the lower
// - all tile registers share one clock, one clock enable, one clear
// - sign control high means operand is two's complement, low means unsigned
// - product is signed when either operand is signed, else unsigned
// - one sign control per operand; both dual lanes share them
// - sign controls may change each cycle and have own optional register
// - product keeps full precision for every sign combination
// - optional output registers: two 18-bit sections or one 36-bit
// - tile runs as one 18x18 or two independent 9x9 multipliers
// - unused sign controls leave the multiplier unsigned
// - widths between 9 and 18 bits use one or two products
`ifndef MULT_TILE_CONSTS_SVH
`define MULT_TILE_CONSTS_SVH

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define OFF_CFG 12'h000
`define OFF_STATUS 12'h004
`define OFF_PROD_LO 12'h008
`define OFF_PROD_HI 12'h00c
`define CFG_RESET 11'h000

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CFG_W 11
`define CFG_LANE0_MSB 7
`define CFG_LANE1_MSB 10
`define CFG_LANE1_LSB 8
`define STAT_SIGNED_BIT 0
`define STAT_DUAL_BIT 1
`define STAT_CE_BIT 2
`define PROD_HI_LSB 32

// ------------------------------------------------------------
// datapath widths
// ------------------------------------------------------------
`define SEC_W 9
`define OP_W 18
`define PROD_W 36

`endif

/* verilog/mult_tile_pkg.sv */
// types of the hard multiplier tile
package mult_tile_pkg;

    typedef enum logic {
        MODE_WIDE,
        MODE_DUAL
    } mode_t;

    // control register layout, msb first
    typedef struct packed {
        logic sign_b_en;
        logic sign_a_en;
        logic out_hi;
        logic out_lo;
        logic sign_b_reg;
        logic sign_a_reg;
        logic in_b_hi;
        logic in_b_lo;
        logic in_a_hi;
        logic in_a_lo;
        mode_t mode;
    } cfg_t;

    typedef enum logic {
        PH_IDLE,
        PH_READY
    } apb_phase_t;

    typedef struct packed {
        cfg_t cfg;
        logic [31:0] prdata;
        apb_phase_t phase;
    } tile_state_t;

endpackage : mult_tile_pkg

/* verilog/pipe_stage.sv */
// one optional register stage with bypass
`timescale 1ns/1ps
`default_nettype none
module pipe_stage #(
    parameter int W = 9
) (
    // shared controls
    input wire logic clk,
    input wire logic ce,
    input wire logic aclr_n,
    // selection and data
    input wire logic use_reg,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] q;
    } stage_t;

    stage_t stage_reg;
    stage_t stage_next;

    always_comb begin
        stage_next = stage_reg;
        if (ce) begin
            stage_next.q = d;
        end
    end

    always_ff @(posedge clk or negedge aclr_n) begin
        if (!aclr_n) begin
            stage_reg <= '0;
        end else begin
            stage_reg <= stage_next;
        end
    end

    assign q = use_reg ? stage_reg.q : d;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_stage_bypass: assert property (@(posedge clk) disable iff (!aclr_n)
        !use_reg |-> q == d) else $error("bypassed stage does not pass data");
    a_stage_load: assert property (@(posedge clk) disable iff (!aclr_n)
        ce ##1 use_reg |-> q == $past(d)) else $error("stage missed its load");
    a_stage_hold: assert property (@(posedge clk) disable iff (!aclr_n)
        !ce && use_reg ##1 use_reg |-> q == $past(q)) else $error("stage moved with enable low");
    // the second edge under clear is checked so a missed start-up edge cannot fool it
    a_stage_clear: assert property (@(posedge clk)
        !aclr_n ##1 !aclr_n |-> stage_reg.q == '0) else $error("stage not zero under clear");

endmodule : pipe_stage
`default_nettype wire

/* verilog/signed_mult.sv */
// full precision multiplier with per operand sign selection
`timescale 1ns/1ps
`default_nettype none
module signed_mult #(
    parameter int W = 9
) (
    // operands
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic sa,
    input wire logic sb,
    // product
    output logic [2*W-1:0] p
);
    logic signed [W:0] ax;
    logic signed [W:0] bx;
    logic signed [2*W+1:0] full;

    // one extra bit makes unsigned and signed operands share one signed multiply
    assign ax = {sa & a[W-1], a};
    assign bx = {sb & b[W-1], b};
    assign full = ax * bx;
    // the product of the extended values always fits in 2W bits
    assign p = full[2*W-1:0];

endmodule : signed_mult
`default_nettype wire
